// ---- hdl/sarm_defines.vh ----
// How it works
// [R1] Run and comparator bits decode operating state
// [R2] Software waits 1 us comparator-to-run
// [R3] Software discards early first result
// [R4] Software waits 1 us after low-voltage mode
// [R5] Software stops conversion before changing rates
// [R6] Standard mode dividers, 22 clock conversions
// [R7] High-speed 2 like standard; high-speed 1 limited
// [R8] Low-voltage mode uses 44 clock conversions
// [R9] Mode register resets to zero
// [R10] Result word: ten bits, upper six zero
// [R11] Upper two bits high byte, eight low
// [R12] Result word: 16-bit read only, resets zero
// [R13] Low byte view, 8-bit reads
// [R14] Software reads result before reconfiguring
// [R15] Result reads insert one wait cycle
// [R16] Mode writes insert one wait cycle
// [R17] Mode register takes bit and byte writes
// [R18] Repeat conversions, request after each
// [R19] Approximation resolves MSB first, then transfers
// [R20] High byte view holds upper eight bits
// [R21] Clearing run aborts without result or request
// [R22] Prohibited settings never start a conversion
`ifndef SARM_DEFINES_VH
`define SARM_DEFINES_VH

`define SARM_ADDR_RESULT    16'hff08
`define SARM_ADDR_RES_HI    16'hff09
`define SARM_ADDR_MODE      16'hff28

`define SARM_MODE_RST       8'h00
`define SARM_RESULT_RST     10'h000

`define SARM_BIT_RUN        7
`define SARM_BIT_RSV        6
`define SARM_FR_HI          5
`define SARM_FR_LO          3
`define SARM_LV_HI          2
`define SARM_LV_LO          1
`define SARM_BIT_COMP       0

`define SARM_LV_STD         2'b00
`define SARM_LV_LOWV        2'b01
`define SARM_LV_HS1         2'b10
`define SARM_LV_HS2         2'b11

`define SARM_FR_HS1_A       3'b100
`define SARM_FR_HS1_B       3'b110

`define SARM_LEN_NORM       6'd22
`define SARM_LEN_LOWV       6'd44
`define SARM_RES_BITS       6'd10

// Divider thresholds in half reference periods, so 1.5 is exact
`define SARM_DIV_X2_0       5'd24
`define SARM_DIV_X2_1       5'd16
`define SARM_DIV_X2_2       5'd12
`define SARM_DIV_X2_3       5'd8
`define SARM_DIV_X2_4       5'd6
`define SARM_DIV_X2_5       5'd4
`define SARM_DIV_X2_6       5'd3
`define SARM_DIV_X2_7       5'd2
`define SARM_DIV_STEP       5'd2

`endif

// ---- hdl/sarm_clkdiv.v ----
`timescale 1ns/1ps
`include "sarm_defines.vh"

module sarm_clkdiv
(
   input  wire       ref_clk_i,
   input  wire       rstn_i,
   input  wire       run_i,
   input  wire [2:0] rate_i,
   output wire       tick_o
);

   reg  [4:0] acc_q;
   reg        tick_q;
   reg  [4:0] thr;
   wire [4:0] sum;

   // Fractional accumulator: adds two per cycle against twice the divider, ticks once per divider
   always @*
   begin
      case (rate_i)                                       // [R6]
         3'd0:    thr = `SARM_DIV_X2_0;
         3'd1:    thr = `SARM_DIV_X2_1;
         3'd2:    thr = `SARM_DIV_X2_2;
         3'd3:    thr = `SARM_DIV_X2_3;
         3'd4:    thr = `SARM_DIV_X2_4;
         3'd5:    thr = `SARM_DIV_X2_5;
         3'd6:    thr = `SARM_DIV_X2_6;
         default: thr = `SARM_DIV_X2_7;
      endcase
   end

   assign sum = acc_q + `SARM_DIV_STEP;

   always @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         acc_q  <= 5'h00;
         tick_q <= 1'b0;
      end
      else if (!run_i)
      begin
         acc_q  <= 5'h00;
         tick_q <= 1'b0;
      end
      else if (sum >= thr)
      begin
         acc_q  <= sum - thr;
         tick_q <= 1'b1;
      end
      else
      begin
         acc_q  <= sum;
         tick_q <= 1'b0;
      end
   end

   assign tick_o = tick_q;

endmodule // sarm_clkdiv

// ---- hdl/sarm_engine.v ----
`timescale 1ns/1ps
`include "sarm_defines.vh"

module sarm_engine
(
   input  wire       ref_clk_i,
   input  wire       rstn_i,
   input  wire       run_i,
   input  wire       tick_i,
   input  wire [5:0] len_i,
   input  wire       comp_i,
   output wire       sample_o,
   output wire [9:0] trial_o,
   output wire       done_o,
   output wire [9:0] result_o
);

   reg  [5:0] cnt_q;
   reg  [9:0] sar_q;
   reg  [9:0] res_q;
   reg        done_q;
   wire [5:0] samp_end;
   wire [5:0] bidx6;
   wire [9:0] onehot;
   wire [9:0] kept;
   wire [9:0] nxt;
   wire       in_samp;
   wire       last;

   assign samp_end = len_i - `SARM_RES_BITS;
   assign in_samp  = cnt_q < samp_end;
   assign bidx6    = len_i - 6'd1 - cnt_q;
   assign onehot   = 10'h001 << bidx6[3:0];
   // Comparator high means the held input is at or above the trial level
   assign kept     = comp_i ? sar_q : (sar_q & ~onehot);
   assign nxt      = kept | (onehot >> 1);
   assign last     = cnt_q == (len_i - 6'd1);

   always @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_q  <= 6'h00;
         sar_q  <= 10'h000;
         res_q  <= `SARM_RESULT_RST;
         done_q <= 1'b0;
      end
      else if (!run_i)
      begin
         // Abort drops the partial result and raises nothing
         cnt_q  <= 6'h00;                                 // [R21]
         sar_q  <= 10'h000;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (tick_i)
         begin
            if (in_samp)
            begin
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == samp_end - 6'd1)
                  sar_q <= 10'h200;                       // [R19]
            end
            else if (last)
            begin
               res_q  <= kept;                            // [R19]
               done_q <= 1'b1;                            // [R18]
               cnt_q  <= 6'h00;
               sar_q  <= 10'h000;
            end
            else
            begin
               sar_q <= nxt;                              // [R19]
               cnt_q <= cnt_q + 6'd1;
            end
         end
      end
   end

   assign sample_o = run_i & in_samp;
   assign trial_o  = sar_q;
   assign done_o   = done_q;
   assign result_o = res_q;

endmodule // sarm_engine

// ---- hdl/sarm_top.v ----
`timescale 1ns/1ps
`include "sarm_defines.vh"

module sarm_top
(
   input  wire        ref_clk_i,
   input  wire        rstn_i,
   input  wire [15:0] bus_addr_i,
   input  wire        bus_rd_i,
   input  wire        bus_wr_i,
   input  wire        bus_word_i,
   input  wire        bus_bit_i,
   input  wire [2:0]  bus_bit_idx_i,
   input  wire [7:0]  bus_wdata_i,
   output wire [15:0] bus_rdata_o,
   output wire        bus_wait_o,
   output wire        bus_ack_o,
   input  wire        comp_i,
   output wire        comparator_power_on_o,
   output wire        sample_o,
   output wire [9:0]  trial_o,
   output wire        conversion_active_o,
   output wire        conversion_done_request_o
);

   ////////////////////////////////////////////////////////////////////////
   // Mode register and decode

   reg  [7:0]  mode_q;
   reg  [7:0]  mode_d;
   wire        conversion_run;
   wire        comparator_power_on;
   wire [2:0]  rate_sel;
   wire [1:0]  speed_voltage_mode;
   reg         setting_ok;
   wire        conv_en;
   wire [5:0]  conv_len;

   assign conversion_run      = mode_q[`SARM_BIT_RUN];
   assign comparator_power_on = mode_q[`SARM_BIT_COMP];
   assign rate_sel            = mode_q[`SARM_FR_HI:`SARM_FR_LO];
   assign speed_voltage_mode  = mode_q[`SARM_LV_HI:`SARM_LV_LO];

   always @*
   begin
      case (speed_voltage_mode)
         `SARM_LV_STD:  setting_ok = 1'b1;                // [R6]
         `SARM_LV_HS2:  setting_ok = 1'b1;                // [R7]
         `SARM_LV_LOWV: setting_ok = 1'b1;                // [R8]
         `SARM_LV_HS1:  setting_ok = (rate_sel == `SARM_FR_HS1_A) ||
                                     (rate_sel == `SARM_FR_HS1_B);  // [R7]
         default:       setting_ok = 1'b0;
      endcase
   end

   // Run without comparator power is prohibited, so nothing runs then
   assign conv_en  = conversion_run & comparator_power_on & setting_ok;  // [R1] [R22]
   assign conv_len = (speed_voltage_mode == `SARM_LV_LOWV) ?
                     `SARM_LEN_LOWV : `SARM_LEN_NORM;     // [R8]

   ////////////////////////////////////////////////////////////////////////
   // Conversion clock and approximation engine

   wire        conv_tick;
   wire        done;
   wire [9:0]  result;

   sarm_clkdiv u_div
   (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .run_i     (conv_en),
      .rate_i    (rate_sel),
      .tick_o    (conv_tick)
   );

   sarm_engine u_eng
   (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .run_i     (conv_en),
      .tick_i    (conv_tick),
      .len_i     (conv_len),
      .comp_i    (comp_i),
      .sample_o  (sample_o),
      .trial_o   (trial_o),
      .done_o    (done),
      .result_o  (result)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus slave

   reg         busy_q;
   reg         ack_q;
   reg  [15:0] rdata_q;
   reg  [15:0] rdata_d;
   wire        req;
   wire        hit_mode;
   wire        hit_res;
   wire        hit_hi;
   wire        need_wait;
   wire        take;
   wire        commit;

   assign req       = bus_rd_i | bus_wr_i;
   assign hit_mode  = bus_addr_i == `SARM_ADDR_MODE;
   assign hit_res   = bus_addr_i == `SARM_ADDR_RESULT;
   assign hit_hi    = bus_addr_i == `SARM_ADDR_RES_HI;
   // Every result view and every mode write costs one wait cycle
   assign need_wait = (bus_rd_i & (hit_res | hit_hi)) |
                      (bus_wr_i & hit_mode);              // [R15] [R16]
   assign take      = req & ~busy_q & ~ack_q;
   assign commit    = (take & ~need_wait) | busy_q;

   always @*
   begin
      mode_d = mode_q;
      if (bus_wr_i & hit_mode & ~bus_word_i)
      begin
         if (bus_bit_i)
            mode_d[bus_bit_idx_i] = bus_wdata_i[0];       // [R17]
         else
            mode_d = bus_wdata_i;                         // [R17]
         mode_d[`SARM_BIT_RSV] = 1'b0;
      end
   end

   always @*
   begin
      rdata_d = 16'h0000;
      if (bus_rd_i)
      begin
         if (hit_mode & ~bus_word_i)
            rdata_d = {8'h00, mode_q};
         else if (hit_res & bus_word_i)
            rdata_d = {6'h00, result};                    // [R10] [R11] [R12]
         else if (hit_res)
            rdata_d = {8'h00, result[7:0]};               // [R13]
         else if (hit_hi & ~bus_word_i)
            rdata_d = {8'h00, result[9:2]};               // [R20]
      end
   end

   always @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mode_q  <= `SARM_MODE_RST;                       // [R9]
         busy_q  <= 1'b0;
         ack_q   <= 1'b0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         busy_q <= take & need_wait;                      // [R15] [R16]
         ack_q  <= commit;
         if (commit)
         begin
            mode_q  <= mode_d;
            rdata_q <= rdata_d;
         end
      end
   end

   assign bus_rdata_o               = rdata_q;
   assign bus_wait_o                = busy_q;
   assign bus_ack_o                 = ack_q;
   assign comparator_power_on_o     = comparator_power_on;
   assign conversion_active_o       = conv_en;
   assign conversion_done_request_o = done;                // [R18]

endmodule // sarm_top

// ---- tb/sarm_sva.sv ----
`timescale 1ns/1ps
module sarm_sva
(
   input wire        ref_clk_i,
   input wire        rstn_i,
   input wire [15:0] bus_addr_i,
   input wire        bus_rd_i,
   input wire        bus_wr_i,
   input wire        bus_word_i,
   input wire [15:0] bus_rdata_o,
   input wire        bus_wait_o,
   input wire        bus_ack_o,
   input wire        comparator_power_on_o,
   input wire        conversion_active_o,
   input wire        conversion_done_request_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // Result reads wait at both byte addresses; the word itself answers at ff08 only
   wire res_a = bus_addr_i[15:1] == 15'h7f84;
   wire mod_a = bus_addr_i == 16'hff28;
   wire done  = conversion_done_request_o;
   ////////////////////////////////////////////////////////////////////////////////
   property p_act; conversion_active_o |-> comparator_power_on_o; endproperty
   a_act: assert property (p_act) else $error("active without comparator");
   property p_rst; $rose(rstn_i) |-> !conversion_active_o && !comparator_power_on_o; endproperty
   a_rst: assert property (p_rst) else $error("mode not idle after reset");
   property p_rwt; $rose(bus_rd_i) && res_a |=> bus_wait_o ##1 bus_ack_o; endproperty
   a_rwt: assert property (p_rwt) else $error("result read without wait");
   property p_mwt; $rose(bus_wr_i) && mod_a |=> bus_wait_o ##1 bus_ack_o; endproperty
   a_mwt: assert property (p_mwt) else $error("mode write without wait");
   property p_mrd; $rose(bus_rd_i) && mod_a |=> bus_ack_o && !bus_wait_o; endproperty
   a_mrd: assert property (p_mrd) else $error("mode read timing");
   property p_owr; $rose(bus_wr_i) && !mod_a |=> bus_ack_o && !bus_wait_o; endproperty
   a_owr: assert property (p_owr) else $error("other write timing");
   property p_whi; bus_ack_o && $past(bus_rd_i) && $past(bus_word_i) |-> bus_rdata_o[15:10] == 6'h00;
   endproperty
   a_whi: assert property (p_whi) else $error("word upper bits set");
   property p_don; done |=> !done [*8]; endproperty
   a_don: assert property (p_don) else $error("done requests too close");
   property p_dac; done |-> $past(conversion_active_o); endproperty
   a_dac: assert property (p_dac) else $error("done while not converting");
   c_done: cover property (done);
   c_wait: cover property (bus_wait_o);
   c_stop: cover property ($fell(conversion_active_o));
endmodule // sarm_sva

bind sarm_top sarm_sva i_sva
(
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_addr_i(bus_addr_i),
   .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i), .bus_word_i(bus_word_i),
   .bus_rdata_o(bus_rdata_o), .bus_wait_o(bus_wait_o), .bus_ack_o(bus_ack_o),
   .comparator_power_on_o(comparator_power_on_o), .conversion_active_o(conversion_active_o),
   .conversion_done_request_o(conversion_done_request_o)
);

// ---- tb/sarm_top_bench.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, s) \
   begin cmp_count = cmp_count + 1; if ((s) !== (e)) begin n_mismatch = n_mismatch + 1; \
   $display("wrong value %s exp %h got %h", nm, e, s); end end
module sarm_top_bench;
   reg         clk, rst_n, rd, wr, word, bit_w;
   reg  [2:0]  idx;
   reg  [7:0]  wdat;
   reg  [15:0] addr, rdv;
   reg  [9:0]  tgt;
   wire [15:0] rdata;
   wire [9:0]  trial;
   wire        wt, ack, cpo, smp, act, done;
   integer     n_mismatch, cmp_count, cyc, n, i, ns;
   integer     dv [0:7];
   // Ideal comparator: the result settles on the held level tgt
   wire        comp = tgt >= trial;
   sarm_top i_dut
   (
      .ref_clk_i(clk), .rstn_i(rst_n), .bus_addr_i(addr), .bus_rd_i(rd), .bus_wr_i(wr),
      .bus_word_i(word), .bus_bit_i(bit_w), .bus_bit_idx_i(idx), .bus_wdata_i(wdat),
      .bus_rdata_o(rdata), .bus_wait_o(wt), .bus_ack_o(ack), .comp_i(comp),
      .comparator_power_on_o(cpo), .sample_o(smp), .trial_o(trial),
      .conversion_active_o(act), .conversion_done_request_o(done)
   );
   always #2 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task acc(input [15:0] a, input w, input wb, input [7:0] d, input bi, input [2:0] ix);
      integer k;
      reg     sw;
      begin
         @(negedge clk);
         addr = a;
         rd = !w;
         wr = w;
         word = wb;
         wdat = d;
         bit_w = bi;
         idx = ix;
         sw = 0;
         k = 0;
         @(negedge clk);
         while (ack !== 1'b1 && k < 8)
         begin
            sw = sw | wt;
            k = k + 1;
            @(negedge clk);
         end
         rdv = rdata;
         rd = 0;
         wr = 0;
         `CHK("ack", 1'b1, ack)
         `CHK("wait", (w ? a == 16'hff28 : a[15:1] == 15'h7f84), sw)
      end
   endtask
   task wr8(input [15:0] a, input [7:0] d);
      acc(a, 1, 0, d, 0, 0);
   endtask
   task rdc(input [15:0] a, input wb, input [15:0] e);
      begin
         acc(a, 0, wb, 8'h00, 0, 0);
         `CHK("rdata", (wb ? e : {8'h00, e[7:0]}), (wb ? rdv : {8'h00, rdv[7:0]}))
      end
   endtask
   // Counts cycles to the next finish, and sampling cycles from the call on
   task wdone(output integer c);
      begin
         c = 0;
         ns = (smp === 1'b1);
         @(negedge clk);
         while (done !== 1'b1 && c < 2000)
         begin
            c = c + 1;
            if (smp === 1'b1)
               ns = ns + 1;
            @(negedge clk);
         end
      end
   endtask
   // Stop with the old rates first, since rates may not change mid-run
   task per(input [7:0] m, input integer e);
      begin
         rdc(16'hff08, 1, {6'h00, tgt});
         acc(16'hff28, 1, 0, 8'h00, 1, 3'd7);
         wr8(16'hff28, m & 8'h7f);
         repeat (250) @(negedge clk);
         wr8(16'hff28, m);
         wdone(n);
         wdone(n);
         `CHK("period", e, n + 1)
         `CHK("sampling", ((m[2:1] == 2'b01) ? e * 34 / 44 : e * 12 / 22), ns)
      end
   endtask
   task stop_test;
      begin
         if (n_mismatch == 0 && cmp_count > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         stop_test;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {clk, rd, wr, word, bit_w, idx, wdat, addr} = 0;
      rst_n = 0;
      tgt = 10'h2a5;
      {n_mismatch, cmp_count, cyc} = 0;
      dv = '{24, 16, 12, 8, 6, 4, 3, 2};
      repeat (5) @(negedge clk);
      rst_n = 1;
      rdc(16'hff28, 0, 16'h0000);
      rdc(16'hff08, 1, 16'h0000);
      rdc(16'h1234, 1, 16'h0000);
      wr8(16'hff08, 8'h55);
      rdc(16'hff08, 1, 16'h0000);
      wr8(16'hff28, 8'h7f);
      rdc(16'hff28, 0, 16'h003f);
      `CHK("comp power", 1'b1, cpo)
      `CHK("active", 1'b0, act)
      repeat (250) @(negedge clk);
      acc(16'hff28, 1, 0, 8'h01, 1, 3'd7);
      `CHK("active", 1'b1, act)
      wdone(n);
      rdc(16'hff08, 1, 16'h02a5);
      rdc(16'hff08, 0, 16'h00a5);
      rdc(16'hff09, 0, 16'h00a9);
      // New level just after a finish, so the abort lands well inside the next conversion
      wdone(n);
      tgt = 10'h155;
      rdc(16'hff08, 1, 16'h02a5);
      acc(16'hff28, 1, 0, 8'h00, 1, 3'd7);
      n = 0;
      repeat (60) @(negedge clk) if (done === 1'b1) n = n + 1;
      `CHK("aborted done", 0, n)
      rdc(16'hff08, 1, 16'h02a5);
      acc(16'hff28, 1, 0, 8'h01, 1, 3'd7);
      wdone(n);
      rdc(16'hff08, 1, 16'h0155);
      wr8(16'hff28, 8'hbe);
      `CHK("active", 1'b0, act)
      `CHK("comp power", 1'b0, cpo)
      wr8(16'hff28, 8'h3e);
      wr8(16'hff28, 8'h05);
      wr8(16'hff28, 8'h85);
      `CHK("active", 1'b0, act)
      for (i = 0; i < 8; i = i + 1)
         per(8'h81 | (i << 3), 11 * dv[i]);
      per(8'hbb, 44);
      per(8'h83, 528);
      per(8'ha7, 66);
      per(8'hb5, 33);
      per(8'ha5, 66);
      stop_test;
   end
endmodule // sarm_top_bench
